/* core/ifs_status_top.sv */
// i2c status flags with AXI4-Lite register access and interrupt output
//
// Function
// - Status bits 31..15 read as zero; writes to them do nothing.
// - Direction flag held at zero while internal loopback mode is selected.
// - Direction flag is one only as addressed slave transmitter.
// - Direction flag clears on any bus START or STOP condition.
// - Writing one to the direction flag clears it.
// - NACK-sent flag sets after device drives NACK in receive ack cycle.
// - Writing one to the NACK-sent flag clears it.
// - NACK-sent flag clears while module reset or processor reset holds.
// - Bus-busy flag reports whether the bus is occupied or free.
// - Bus-busy flag clears on a detected or generated STOP.
// - Bus-busy flag sets on a detected or generated START.
// - Writing one to the bus-busy flag clears it.
// - Writing zero to any write-one-to-clear flag leaves it unchanged.
`timescale 1ns/1ps
`default_nettype none

module ifs_status_top #(
    // byte address width of the register bus
    parameter int unsigned ADDR_W = ifs_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,

    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,

    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,

    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,

    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,

    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,

    // i2c bus pins as seen by the input buffers
    input  wire logic              sclPin,
    input  wire logic              sdaPin,

    // events from the controller core on the same clock
    input  wire logic              masterMode,
    input  wire logic              slaveTxAddressed,
    input  wire logic              nackDriven,
    input  wire logic              startGenerated,
    input  wire logic              stopGenerated,

    // outputs
    output logic                   irq,
    output logic                   moduleResetRelease,
    output logic                   internalLoopbackMode,
    output logic                   busBusyFlag,
    output logic                   nackSentFlag,
    output logic                   slaveTransmitDirectionFlag
);

    typedef struct packed {
        // write channel capture
        logic              awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic              wHeld;
        logic [31:0]       wData;
        logic [3:0]        wStrb;
        logic              awReady;
        logic              wReady;
        logic              bValid;
        logic [1:0]        bResp;

        // read channel
        logic              arReady;
        logic              rValid;
        logic [31:0]       rData;
        logic [1:0]        rResp;

        // software-visible control
        logic              resetRelease;
        logic              loopback;
        logic [2:0]        mask;
        logic              irq;
    } ifs_top_state_type;

    localparam ifs_top_state_type TOP_RST = '{
        // write channel idle, ready to capture
        awHeld:       1'b0,
        awAddr:       '0,
        wHeld:        1'b0,
        wData:        '0,
        wStrb:        '0,
        awReady:      1'b1,
        wReady:       1'b1,
        bValid:       1'b0,
        bResp:        ifs_pkg::RESP_OKAY,
        // read channel idle
        arReady:      1'b1,
        rValid:       1'b0,
        rData:        '0,
        rResp:        ifs_pkg::RESP_OKAY,
        // module held in reset, loopback off, all masked
        resetRelease: ifs_pkg::CTRL_RELEASE_RST,
        loopback:     ifs_pkg::CTRL_LOOPBACK_RST,
        mask:         ifs_pkg::MASK_RST,
        irq:          1'b0
    };

    ifs_top_state_type state_q;
    ifs_top_state_type state_d;

    // bus condition detection
    logic startSeen;
    logic stopSeen;
    logic busStart;
    logic busStop;

    ifs_bus_monitor u_monitor (
        .clk       (clk),
        .reset_n   (reset_n),
        .sclPin    (sclPin),
        .sdaPin    (sdaPin),
        .startSeen (startSeen),
        .stopSeen  (stopSeen),
        .sclHigh   ()
    );

    // a condition counts whether seen on the pins or made here
    assign busStart = startSeen || startGenerated;
    assign busStop  = stopSeen || stopGenerated;

    // flag bank control
    logic [ifs_pkg::FLAG_COUNT-1:0] flagSet;
    logic [ifs_pkg::FLAG_COUNT-1:0] flagClr;
    logic [ifs_pkg::FLAG_COUNT-1:0] flagHold;
    logic [ifs_pkg::FLAG_COUNT-1:0] flags;

    ifs_flag_bank #(
        .N (ifs_pkg::FLAG_COUNT)
    ) u_flags (
        .clk     (clk),
        .reset_n (reset_n),
        .setEvt  (flagSet),
        .clrEvt  (flagClr),
        .holdClr (flagHold),
        .flags   (flags)
    );

    // write decode, shared by the register update and the w1c pulses
    logic        writeCommit;
    logic        writeCtrl;
    logic        writeMask;
    logic        writeStatus;
    logic        writeMapped;

    // clear pulses and the word a status read returns
    logic [31:0] w1cBits;
    logic [31:0] statusWord;

    always_comb begin
        writeCommit = state_q.awHeld && state_q.wHeld && !state_q.bValid;
        writeCtrl   = writeCommit && (state_q.awAddr == ifs_pkg::OFFS_CONTROL);
        writeMask   = writeCommit && (state_q.awAddr == ifs_pkg::OFFS_MASK);
        writeStatus = writeCommit && (state_q.awAddr == ifs_pkg::OFFS_STATUS);
        writeMapped = writeCtrl || writeMask || writeStatus;

        // only ones on implemented bits clear; zeros and upper bits ignored
        w1cBits     = '0;
        if (writeStatus && state_q.wStrb[ifs_pkg::STAT_LANE]) begin
            w1cBits = state_q.wData & ifs_pkg::STAT_IMPL_MASK;
        end
    end

    // assemble the readable status word; upper bits stay zero
    always_comb begin
        statusWord = '0;
        statusWord[ifs_pkg::STAT_BUS_BUSY]     = flags[ifs_pkg::FLAG_BB];
        statusWord[ifs_pkg::STAT_NACK_SENT]    = flags[ifs_pkg::FLAG_NACK];
        statusWord[ifs_pkg::STAT_SLAVE_TX_DIR] = flags[ifs_pkg::FLAG_SLAVE_TRANSMIT_DIRECTION_FLAG];
    end

    // flags that are set and enabled in the mask
    logic [ifs_pkg::FLAG_COUNT-1:0] pendingFlags;

    always_comb begin
        pendingFlags = statusWord[ifs_pkg::STAT_SLAVE_TX_DIR:ifs_pkg::STAT_BUS_BUSY]
                       & state_q.mask;
    end

    // set, clear and hold terms of each flag
    always_comb begin
        // bus busy follows bus conditions seen or made by this device
        flagSet[ifs_pkg::FLAG_BB]   = busStart;
        flagClr[ifs_pkg::FLAG_BB]   = busStop
                                      || w1cBits[ifs_pkg::STAT_BUS_BUSY];
        flagHold[ifs_pkg::FLAG_BB]  = !state_q.resetRelease;

        // nack sent: core pulses only for a nack it drove as receiver
        flagSet[ifs_pkg::FLAG_NACK]  = nackDriven;
        flagClr[ifs_pkg::FLAG_NACK]  = w1cBits[ifs_pkg::STAT_NACK_SENT];
        flagHold[ifs_pkg::FLAG_NACK] = !state_q.resetRelease;

        // slave transmit direction
        flagSet[ifs_pkg::FLAG_SLAVE_TRANSMIT_DIRECTION_FLAG]  = slaveTxAddressed && !masterMode;
        flagClr[ifs_pkg::FLAG_SLAVE_TRANSMIT_DIRECTION_FLAG]  = busStart || busStop
                                       || masterMode
                                       || w1cBits[ifs_pkg::STAT_SLAVE_TX_DIR];
        flagHold[ifs_pkg::FLAG_SLAVE_TRANSMIT_DIRECTION_FLAG] = state_q.loopback
                                       || !state_q.resetRelease;
    end

    // bus slave, control registers and interrupt
    always_comb begin
        state_d = state_q;

        // capture write address and data in either order
        if (s_axi_awvalid && state_q.awReady) begin
            state_d.awHeld  = 1'b1;
            state_d.awAddr  = s_axi_awaddr;
            state_d.awReady = 1'b0;
        end

        // data half, taken independently of the address half
        if (s_axi_wvalid && state_q.wReady) begin
            state_d.wHeld  = 1'b1;
            state_d.wData  = s_axi_wdata;
            state_d.wStrb  = s_axi_wstrb;
            state_d.wReady = 1'b0;
        end

        // both halves present: update registers and answer
        if (writeCommit) begin
            state_d.awHeld = 1'b0;
            state_d.wHeld  = 1'b0;
            state_d.bValid = 1'b1;
            state_d.bResp  = writeMapped ? ifs_pkg::RESP_OKAY : ifs_pkg::RESP_SLVERR;

            // control bits live in byte lane zero
            if (writeCtrl && state_q.wStrb[ifs_pkg::CTRL_LANE]) begin
                state_d.resetRelease = state_q.wData[ifs_pkg::CTRL_RESET_RELEASE];
                state_d.loopback     = state_q.wData[ifs_pkg::CTRL_LOOPBACK];
            end

            // mask bits share the status layout in byte lane one
            if (writeMask && state_q.wStrb[ifs_pkg::STAT_LANE]) begin
                state_d.mask = state_q.wData[ifs_pkg::STAT_SLAVE_TX_DIR:
                                             ifs_pkg::STAT_BUS_BUSY];
            end
        end

        // response taken: reopen both capture channels
        if (state_q.bValid && s_axi_bready) begin
            state_d.bValid  = 1'b0;
            state_d.awReady = 1'b1;
            state_d.wReady  = 1'b1;
        end

        // read: one outstanding, data sampled at acceptance
        if (s_axi_arvalid && state_q.arReady) begin
            state_d.arReady = 1'b0;
            state_d.rValid  = 1'b1;
            state_d.rResp   = ifs_pkg::RESP_OKAY;
            state_d.rData   = '0;

            unique case (s_axi_araddr)
                // reset release and loopback bits
                ifs_pkg::OFFS_CONTROL: begin
                    state_d.rData[ifs_pkg::CTRL_RESET_RELEASE] = state_q.resetRelease;
                    state_d.rData[ifs_pkg::CTRL_LOOPBACK]      = state_q.loopback;
                end
                // enables in the status layout
                ifs_pkg::OFFS_MASK: begin
                    state_d.rData[ifs_pkg::STAT_SLAVE_TX_DIR:
                                  ifs_pkg::STAT_BUS_BUSY] = state_q.mask;
                end
                // flags, reserved bits zero
                ifs_pkg::OFFS_STATUS: begin
                    state_d.rData = statusWord;
                end
                // unmapped: zero data, error response
                default: begin
                    state_d.rResp = ifs_pkg::RESP_SLVERR;
                end
            endcase
        end

        // read data taken: reopen the address channel
        if (state_q.rValid && s_axi_rready) begin
            state_d.rValid  = 1'b0;
            state_d.arReady = 1'b1;
        end

        // level interrupt from any unmasked flag
        state_d.irq = |pendingFlags;
    end

    // one register stage for all top-level state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= TOP_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // all outputs straight from flip-flops
    assign s_axi_awready              = state_q.awReady;
    assign s_axi_wready               = state_q.wReady;
    assign s_axi_bvalid               = state_q.bValid;
    assign s_axi_bresp                = state_q.bResp;

    // read channel handshake and data
    assign s_axi_arready              = state_q.arReady;
    assign s_axi_rvalid               = state_q.rValid;
    assign s_axi_rdata                = state_q.rData;
    assign s_axi_rresp                = state_q.rResp;

    // interrupt and control bits
    assign irq                        = state_q.irq;
    assign moduleResetRelease         = state_q.resetRelease;
    assign internalLoopbackMode       = state_q.loopback;

    // flag copies, each a flip-flop in the flag bank
    assign busBusyFlag                = flags[ifs_pkg::FLAG_BB];
    assign nackSentFlag               = flags[ifs_pkg::FLAG_NACK];
    assign slaveTransmitDirectionFlag = flags[ifs_pkg::FLAG_SLAVE_TRANSMIT_DIRECTION_FLAG];

endmodule

`default_nettype wire

/* core/ifs_pkg.sv */
// shared constants for the i2c status-flag block
package ifs_pkg;

    // register byte offsets on the AXI4-Lite slave
    localparam int unsigned ADDR_W             = 8;
    localparam logic [7:0]  OFFS_CONTROL       = 8'h00;
    localparam logic [7:0]  OFFS_MASK          = 8'h04;
    localparam logic [7:0]  OFFS_STATUS        = 8'h08;

    // interrupt_status / mask field positions
    localparam int unsigned STAT_BUS_BUSY      = 12;
    localparam int unsigned STAT_NACK_SENT     = 13;
    localparam int unsigned STAT_SLAVE_TX_DIR  = 14;
    localparam logic [31:0] STAT_IMPL_MASK     = 32'h0000_7000;
    localparam int unsigned STAT_LANE          = 1;

    // control register field positions and reset values
    localparam int unsigned CTRL_RESET_RELEASE = 0;
    localparam int unsigned CTRL_LOOPBACK      = 1;
    localparam int unsigned CTRL_LANE          = 0;
    localparam logic        CTRL_RELEASE_RST   = 1'b0;
    localparam logic        CTRL_LOOPBACK_RST  = 1'b0;
    localparam logic [2:0]  MASK_RST           = 3'h0;

    // index of each flag inside the flag bank
    localparam int unsigned FLAG_COUNT         = 3;
    localparam int unsigned FLAG_BB            = 0;
    localparam int unsigned FLAG_NACK          = 1;
    localparam int unsigned FLAG_SLAVE_TRANSMIT_DIRECTION_FLAG          = 2;

    // AXI response codes
    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

    // idle level of the bus pins after reset
    localparam logic        PIN_IDLE           = 1'b1;

endpackage

/* core/ifs_bus_monitor.sv */
// pin synchronisers and START/STOP detection on the sampled bus
`timescale 1ns/1ps
`default_nettype none

module ifs_bus_monitor (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic sclPin,
    input  wire logic sdaPin,
    output logic      startSeen,
    output logic      stopSeen,
    output logic      sclHigh
);

    typedef struct packed {
        logic sclMeta;
        logic sdaMeta;
        logic sclSync;
        logic sdaSync;
        logic sclPrev;
        logic sdaPrev;
        logic start;
        logic stop;
    } ifs_mon_state_type;

    localparam ifs_mon_state_type MON_RST = '{
        sclMeta: ifs_pkg::PIN_IDLE, sdaMeta: ifs_pkg::PIN_IDLE,
        sclSync: ifs_pkg::PIN_IDLE, sdaSync: ifs_pkg::PIN_IDLE,
        sclPrev: ifs_pkg::PIN_IDLE, sdaPrev: ifs_pkg::PIN_IDLE,
        start: 1'b0, stop: 1'b0};

    ifs_mon_state_type state_q;
    ifs_mon_state_type state_d;

    // two-stage sync, then edge detect on the second stage only
    always_comb begin
        state_d         = state_q;
        state_d.sclMeta = sclPin;
        state_d.sdaMeta = sdaPin;
        state_d.sclSync = state_q.sclMeta;
        state_d.sdaSync = state_q.sdaMeta;
        state_d.sclPrev = state_q.sclSync;
        state_d.sdaPrev = state_q.sdaSync;
        // sda falls while scl stays high
        state_d.start   = state_q.sclSync && state_q.sclPrev
                          && state_q.sdaPrev && !state_q.sdaSync;
        // sda rises while scl stays high
        state_d.stop    = state_q.sclSync && state_q.sclPrev
                          && !state_q.sdaPrev && state_q.sdaSync;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= MON_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign startSeen = state_q.start;
    assign stopSeen  = state_q.stop;
    assign sclHigh   = state_q.sclPrev;

endmodule

`default_nettype wire

/* core/ifs_flag_bank.sv */
// bank of sticky status flags: set wins over clear, hold-clear wins over all
`timescale 1ns/1ps
`default_nettype none

module ifs_flag_bank #(
    parameter int unsigned N = 3
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [N-1:0] setEvt,
    input  wire logic [N-1:0] clrEvt,
    input  wire logic [N-1:0] holdClr,
    output logic      [N-1:0] flags
);

    typedef struct packed {
        logic [N-1:0] flag;
    } ifs_flag_state_type;

    ifs_flag_state_type state_q;
    ifs_flag_state_type state_d;
    logic [N-1:0]       flagNext;

    // per-flag next value
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            assign flagNext[i] = !holdClr[i]
                                 && (setEvt[i] || (state_q.flag[i] && !clrEvt[i]));
        end
    endgenerate

    always_comb begin
        state_d      = state_q;
        state_d.flag = flagNext;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign flags = state_q.flag;

endmodule

`default_nettype wire

/* dv/ifs_bus_model.sv */
// behavioural peer on the i2c pins, open-drain lines with pull-ups
`timescale 1ns/1ps
`default_nettype none

module ifs_bus_model (
    output logic sclPin,
    output logic sdaPin
);
    // released lines rest at the pull-up level, clock stands still
    initial begin
        sclPin = 1'b1;
        sdaPin = 1'b1;
    end
    // sda falls while scl is high, then scl is pulled low
    task automatic frame_start();
        sdaPin = 1'b0;
        #62.5 sclPin = 1'b0;
        #31;
    endtask
    // one data bit at a 125 ns clock period
    task automatic send_bit(input logic b);
        sdaPin = b;
        #31 sclPin = 1'b1;
        #62.5 sclPin = 1'b0;
        #31.5;
    endtask
    // sda rises while scl is high, then both lines are released
    task automatic frame_stop();
        sdaPin = 1'b0;
        #31 sclPin = 1'b1;
        #62.5 sdaPin = 1'b1;
        #62.5;
    endtask
endmodule
`default_nettype wire

/* dv/ifs_status_checker.sv */
// port assertions for the status-flag block
`timescale 1ns/1ps
`default_nettype none

module ifs_status_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        masterMode,
    input wire logic        slaveTxAddressed,
    input wire logic        nackDriven,
    input wire logic        startGenerated,
    input wire logic        stopGenerated,
    input wire logic        irq,
    input wire logic        moduleResetRelease,
    input wire logic        internalLoopbackMode,
    input wire logic        busBusyFlag,
    input wire logic        nackSentFlag,
    input wire logic        slaveTransmitDirectionFlag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // reserved read bits, then flag relations against their causes
    property p_rsv; s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("upper read bits set");
    property p_loop;
        internalLoopbackMode && $past(internalLoopbackMode) |-> !slaveTransmitDirectionFlag;
    endproperty
    a_loop: assert property (p_loop) else $error("direction set in loopback");
    property p_dir;
        slaveTxAddressed && moduleResetRelease && !internalLoopbackMode && !masterMode
            |=> slaveTransmitDirectionFlag;
    endproperty
    a_dir: assert property (p_dir) else $error("direction not set");
    property p_master; masterMode |=> !slaveTransmitDirectionFlag; endproperty
    a_master: assert property (p_master) else $error("direction set as master");
    property p_cond;
        (startGenerated || stopGenerated) && !slaveTxAddressed |=> !slaveTransmitDirectionFlag;
    endproperty
    a_cond: assert property (p_cond) else $error("direction kept over condition");
    property p_nack; nackDriven && moduleResetRelease |=> nackSentFlag; endproperty
    a_nack: assert property (p_nack) else $error("nack flag not set");
    property p_nrst; !moduleResetRelease |=> !nackSentFlag; endproperty
    a_nrst: assert property (p_nrst) else $error("nack flag set in reset");
    property p_start; startGenerated && moduleResetRelease |=> busBusyFlag; endproperty
    a_start: assert property (p_start) else $error("busy not set");
    property p_stop; stopGenerated && !startGenerated |=> !busBusyFlag; endproperty
    a_stop: assert property (p_stop) else $error("busy not cleared");
    property p_irq;
        irq |-> $past(busBusyFlag || nackSentFlag || slaveTransmitDirectionFlag);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without flag");
    // main scenarios reached
    c_dir: cover property (slaveTxAddressed ##1 slaveTransmitDirectionFlag);
    c_irq: cover property ($rose(irq));
    c_busy: cover property ($fell(busBusyFlag));
endmodule

bind ifs_status_top ifs_status_checker chk (.clk, .reset_n, .s_axi_rdata, .s_axi_rvalid,
    .masterMode, .slaveTxAddressed, .nackDriven, .startGenerated, .stopGenerated, .irq,
    .moduleResetRelease, .internalLoopbackMode, .busBusyFlag, .nackSentFlag,
    .slaveTransmitDirectionFlag);
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the status-flag block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [7:0] CT = ifs_pkg::OFFS_CONTROL;
    localparam logic [7:0] MK = ifs_pkg::OFFS_MASK;
    localparam logic [7:0] ST = ifs_pkg::OFFS_STATUS;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        masterMode = 1'b0, slaveTxAddressed = 1'b0, nackDriven = 1'b0;
    logic        startGenerated = 1'b0, stopGenerated = 1'b0;
    logic        irq, moduleResetRelease, internalLoopbackMode, busBusyFlag, nackSentFlag;
    logic        slaveTransmitDirectionFlag, sclPin, sdaPin;
    int          errors = 0, num_checks = 0;
    int          mBb = 0, mNack = 0, mDir = 0, mMask = 0, mCtrl = 0;
    integer      seed = 32'hE518;

    always #2.5 clk = ~clk;
    ifs_status_top dut (.*);
    ifs_bus_model bm (.sclPin(sclPin), .sdaPin(sdaPin));

    // verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 60) begin
            errors++;
            $display("unexpected at %0t: bus wait ran out", $time);
            print_verdict();
        end
    endtask
    // reference model of responses and flags
    function automatic logic [1:0] ersp(input logic [7:0] a);
        return (a == CT || a == MK || a == ST) ? ifs_pkg::RESP_OKAY : ifs_pkg::RESP_SLVERR;
    endfunction
    function automatic int stat();
        return (mDir << 14) | (mNack << 13) | (mBb << 12);
    endfunction
    // axi4-lite write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        guard(n);
        chk({30'h0, s_axi_bresp}, {30'h0, ersp(a)});
        s_axi_bready <= 1'b0;
        if (a == ST && s_axi_wstrb[1]) begin
            mBb = d[12] ? 0 : mBb;
            mNack = d[13] ? 0 : mNack;
            mDir = d[14] ? 0 : mDir;
        end
        if (a == MK && s_axi_wstrb[1]) mMask = d & 32'h7000;
        if (a == CT && s_axi_wstrb[0]) begin
            mCtrl = d & 32'h3;
            if (!d[0]) mBb = 0;
            if (!d[0]) mNack = 0;
            if (!d[0] || d[1]) mDir = 0;
        end
    endtask
    // axi4-lite read, compared with the model
    task automatic look(input logic [7:0] a);
        int n;
        int x;
        x = (a == CT) ? mCtrl : (a == MK) ? mMask : (a == ST) ? stat() : 0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        guard(n);
        chk(s_axi_rdata, x);
        chk({30'h0, s_axi_rresp}, {30'h0, ersp(a)});
        s_axi_rready <= 1'b0;
        chk({31'h0, irq}, 32'((stat() & mMask) != 0));
        chk({29'h0, slaveTransmitDirectionFlag, nackSentFlag, busBusyFlag}, stat() >> 12);
        chk({30'h0, internalLoopbackMode, moduleResetRelease}, mCtrl);
    endtask
    // one-cycle core events: bit0 slave tx, bit1 nack, bit2 start, bit3 stop
    task automatic pulse(input int e);
        @(posedge clk);
        {stopGenerated, startGenerated, nackDriven, slaveTxAddressed} <= 4'(e);
        @(posedge clk);
        {stopGenerated, startGenerated, nackDriven, slaveTxAddressed} <= 4'h0;
        if (mCtrl & 1) begin
            if (e & 12) mDir = 0;
            if (e & 8) mBb = 0;
            if (e & 4) mBb = 1;
            if (e & 2) mNack = 1;
            if ((e & 1) && !masterMode && !(mCtrl & 2)) mDir = 1;
        end
    endtask
    task automatic pstart();
        bm.frame_start();
        mBb = mCtrl & 1;
        mDir = 0;
    endtask
    task automatic pstop();
        bm.frame_stop();
        mBb = 0;
        mDir = 0;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        look(CT);
        look(MK);
        look(ST);
        wr(8'h10, 32'hFFFF_FFFF);
        look(8'h10);
        pulse(15);
        look(ST);
        $display("reset test done");
        wr(CT, 32'h1);
        pulse(1);
        pstart();
        look(ST);
        pulse(1);
        repeat (3) bm.send_bit(1'($random(seed)));
        pstop();
        look(ST);
        pulse(4);
        look(ST);
        pulse(8);
        look(ST);
        $display("busy test done");
        pulse(7);
        wr(ST, $random(seed) & 32'hFFFF_8FFF);
        look(ST);
        s_axi_wstrb <= 4'hD;
        wr(ST, 32'h7000);
        look(ST);
        s_axi_wstrb <= 4'hE;
        wr(CT, 32'h0);
        look(CT);
        s_axi_wstrb <= 4'hF;
        for (int i = 12; i < 15; i++) begin
            wr(ST, (32'h1 << i) | ($random(seed) & 32'hFFFF_8000));
            look(ST);
        end
        $display("clear test done");
        masterMode <= 1'b1;
        pulse(1);
        look(ST);
        masterMode <= 1'b0;
        wr(CT, 32'h3);
        pulse(1);
        look(ST);
        wr(CT, 32'h1);
        pulse(1);
        look(ST);
        $display("direction test done");
        wr(MK, $random(seed));
        look(MK);
        wr(MK, 32'h2000);
        pulse(2);
        look(ST);
        wr(MK, 32'h0);
        look(ST);
        wr(MK, 32'h6000);
        wr(ST, 32'h2000);
        look(ST);
        pulse(2);
        wr(CT, 32'h0);
        look(ST);
        $display("interrupt test done");
        print_verdict();
    end
endmodule
`default_nettype wire
